// file: epd_pkg.sv
// package for the eight-bit general-purpose port: register map, reset values, pad carriers
package epd_pkg;

   localparam int unsigned PORT_W = 8;
   localparam int unsigned ADDR_W = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_PORT_VALUE  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DIRECTION   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_LATCH       = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_ANALOG      = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_THRESHOLD   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_OPEN_DRAIN  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_SLEW        = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_PULLUP      = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_CCD_RISE    = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_CCD_FALL    = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_CCD_CTRL    = 8'h28;

   // field positions
   localparam int unsigned POS_INPUT_ONLY = 3;
   localparam int unsigned POS_CCD_EN     = 7;

   // reset values: applied at every reset
   localparam logic [PORT_W-1:0] RST_ANALOG     = 8'hff;
   localparam logic [PORT_W-1:0] RST_SLEW       = 8'hff;
   localparam logic [PORT_W-1:0] RST_THRESHOLD  = 8'hff;
   localparam logic [PORT_W-1:0] RST_CCD        = 8'h00;
   localparam logic              RST_CCD_EN     = 1'b0;
   // reset values: applied only at power-on or brown-out reset
   localparam logic [PORT_W-1:0] POR_DIRECTION  = 8'hff;
   localparam logic [PORT_W-1:0] POR_LATCH      = 8'h00;
   localparam logic [PORT_W-1:0] POR_PULLUP     = 8'h00;
   localparam logic [PORT_W-1:0] POR_OPEN_DRAIN = 8'h00;

   localparam logic [PORT_W-1:0] INPUT_ONLY_MASK = 8'h08;

   // pad drive controls, one bit per pin
   typedef struct packed {
      logic [PORT_W-1:0] out;
      logic [PORT_W-1:0] oe;
      logic [PORT_W-1:0] slew_limit;
      logic [PORT_W-1:0] pullup_en;
      logic [PORT_W-1:0] ccd_rise;
      logic [PORT_W-1:0] ccd_fall;
   } epd_pad_ctl_s;

   // peripheral outputs already routed by the pin-select mux
   typedef struct packed {
      logic [PORT_W-1:0] sel;
      logic [PORT_W-1:0] data;
      logic [PORT_W-1:0] od_force;
   } epd_periph_s;

endpackage : epd_pkg

// file: epd_port.sv
// eight-bit general-purpose port with APB register access and pad drive control
//
// Notes on behaviour
// - direction 1 turns the pin driver off
// - direction 0 drives the pin from latch
// - eight-bit port; port read returns pin states
// - port write is read-modify-write into latch
// - latch holds the most recent latch/port write
// - direction gates drivers even for analog pins
// - analog-selected pins read as zero digitally, except bit 3, which reads 1 with master clear
// - analog select never affects digital output drive
// - analog select resets to analog; software clears
// - threshold choice governs reads and change detection
// - open-drain bit makes output sink only
// - I2C peripheral forces open-drain by itself
// - slew bit limits the pin slew rate
// - each pin has its own weak pull-up
// - constant current needs pin bit and global enable
// - latch drives pin unless pin-select chooses peripheral
// - bit 3 input-only, reads 1 with master clear
// - port latch keeps value across non-power resets
// - threshold 1 Schmitt, 0 TTL
// - pull-up off whenever the pin is output

module epd_port
   import epd_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                por_reset,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic                     pready,
   output logic     [31:0]          prdata,
   output logic                     pslverr,
   input  wire logic [PORT_W-1:0]   pad_schmitt_in,
   input  wire logic [PORT_W-1:0]   pad_ttl_in,
   input  wire logic                master_clear_pin_enable,
   input  wire epd_periph_s         periph,
   output epd_pad_ctl_s             pad_ctl,
   output logic     [PORT_W-1:0]    pin_digital_in
);

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [PORT_W-1:0] pin_direction_r;
   logic [PORT_W-1:0] output_latch_r;
   logic [PORT_W-1:0] analog_select_r;
   logic [PORT_W-1:0] input_threshold_select_r;
   logic [PORT_W-1:0] open_drain_control_r;
   logic [PORT_W-1:0] slew_limit_control_r;
   logic [PORT_W-1:0] weak_pullup_control_r;
   logic [PORT_W-1:0] const_current_rise_enable_r;
   logic [PORT_W-1:0] const_current_fall_enable_r;
   logic              const_current_global_enable_r;
   logic [31:0]       prdata_r;

   logic [PORT_W-1:0] schmitt_s1_r;
   logic [PORT_W-1:0] schmitt_s2_r;
   logic [PORT_W-1:0] ttl_s1_r;
   logic [PORT_W-1:0] ttl_s2_r;

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers, two stages each

   always_ff @(posedge mclk) begin
      schmitt_s1_r <= pad_schmitt_in;
      schmitt_s2_r <= schmitt_s1_r;
      ttl_s1_r     <= pad_ttl_in;
      ttl_s2_r     <= ttl_s1_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // digital input path

   wire [PORT_W-1:0] thresh_in;
   wire [PORT_W-1:0] port_read;
   wire [PORT_W-1:0] mclr_mask;

   // per-pin choice of input buffer
   assign thresh_in = (input_threshold_select_r & schmitt_s2_r)
                    | (~input_threshold_select_r & ttl_s2_r);
   assign mclr_mask = master_clear_pin_enable ? INPUT_ONLY_MASK : '0;
   // analog pins read zero; master clear forces bit 3 high
   assign port_read      = (thresh_in & ~analog_select_r) | mclr_mask;
   // same value feeds interrupt-on-change and peripheral inputs
   assign pin_digital_in = port_read;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   wire              setup_ph;
   wire              access_ph;
   wire              wr_en;
   wire              addr_hit;
   wire              lane0;
   wire [PORT_W-1:0] wbyte;
   wire [PORT_W-1:0] rd_byte;

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign addr_hit  = (paddr == OFF_PORT_VALUE) | (paddr == OFF_DIRECTION) | (paddr == OFF_LATCH)
                    | (paddr == OFF_ANALOG) | (paddr == OFF_THRESHOLD) | (paddr == OFF_OPEN_DRAIN)
                    | (paddr == OFF_SLEW) | (paddr == OFF_PULLUP) | (paddr == OFF_CCD_RISE)
                    | (paddr == OFF_CCD_FALL) | (paddr == OFF_CCD_CTRL);
   assign wr_en     = access_ph & pwrite & addr_hit;
   assign lane0     = pstrb[0];
   assign wbyte     = pwdata[PORT_W-1:0];

   assign rd_byte = (paddr == OFF_PORT_VALUE) ? port_read                       :
                    (paddr == OFF_DIRECTION)  ? pin_direction_r                 :
                    (paddr == OFF_LATCH)      ? output_latch_r                  :
                    (paddr == OFF_ANALOG)     ? analog_select_r                 :
                    (paddr == OFF_THRESHOLD)  ? input_threshold_select_r        :
                    (paddr == OFF_OPEN_DRAIN) ? open_drain_control_r            :
                    (paddr == OFF_SLEW)       ? slew_limit_control_r            :
                    (paddr == OFF_PULLUP)     ? weak_pullup_control_r           :
                    (paddr == OFF_CCD_RISE)   ? const_current_rise_enable_r     :
                    (paddr == OFF_CCD_FALL)   ? const_current_fall_enable_r     :
                    (paddr == OFF_CCD_CTRL)   ? {const_current_global_enable_r, 7'h00} :
                                                8'h00;

   // zero wait states; read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = access_ph & ~addr_hit;
   assign prdata  = prdata_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata_r <= '0;
      end else if (setup_ph && !pwrite) begin
         prdata_r <= {24'h000000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next values of the software registers

   wire              wr_port;
   wire              wr_latch;
   wire [PORT_W-1:0] latch_src;
   wire [PORT_W-1:0] latch_nxt;
   wire [PORT_W-1:0] dir_nxt;

   assign wr_port  = wr_en & (paddr == OFF_PORT_VALUE);
   assign wr_latch = wr_en & (paddr == OFF_LATCH) & lane0;
   // a port write samples the pins and merges the written lane over them
   assign latch_src = wr_port ? (lane0 ? wbyte : port_read) : wbyte;
   // bit 3 latch is read-only
   assign latch_nxt = (latch_src & ~INPUT_ONLY_MASK) | (output_latch_r & INPUT_ONLY_MASK);
   assign dir_nxt   = wbyte | INPUT_ONLY_MASK;

   // direction, latch, pull-up and open-drain keep their values over warm resets
   always_ff @(posedge mclk) begin
      if (!rst_n && por_reset) begin
         pin_direction_r       <= POR_DIRECTION;
         output_latch_r        <= POR_LATCH;
         weak_pullup_control_r <= POR_PULLUP;
         open_drain_control_r  <= POR_OPEN_DRAIN;
      end else if (rst_n) begin
         if (wr_en && lane0 && paddr == OFF_DIRECTION) begin
            pin_direction_r <= dir_nxt;
         end
         if (wr_port || wr_latch) begin
            output_latch_r <= latch_nxt;
         end
         if (wr_en && lane0 && paddr == OFF_PULLUP) begin
            weak_pullup_control_r <= wbyte;
         end
         if (wr_en && lane0 && paddr == OFF_OPEN_DRAIN) begin
            open_drain_control_r <= wbyte;
         end
      end
   end

   // these take their reset values at every reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         analog_select_r               <= RST_ANALOG;
         input_threshold_select_r      <= RST_THRESHOLD;
         slew_limit_control_r          <= RST_SLEW;
         const_current_rise_enable_r   <= RST_CCD;
         const_current_fall_enable_r   <= RST_CCD;
         const_current_global_enable_r <= RST_CCD_EN;
      end else if (wr_en && lane0) begin
         if (paddr == OFF_ANALOG) begin
            analog_select_r <= wbyte;
         end
         if (paddr == OFF_THRESHOLD) begin
            input_threshold_select_r <= wbyte;
         end
         if (paddr == OFF_SLEW) begin
            slew_limit_control_r <= wbyte;
         end
         if (paddr == OFF_CCD_RISE) begin
            const_current_rise_enable_r <= wbyte;
         end
         if (paddr == OFF_CCD_FALL) begin
            const_current_fall_enable_r <= wbyte;
         end
         if (paddr == OFF_CCD_CTRL) begin
            const_current_global_enable_r <= wbyte[POS_CCD_EN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pad drive

   wire [PORT_W-1:0] drive_en;
   wire [PORT_W-1:0] drive_data;
   wire [PORT_W-1:0] od_mode;

   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi++) begin : g_pin
         // analog select plays no part in the output path
         assign drive_en[gi]   = ~pin_direction_r[gi] & ~INPUT_ONLY_MASK[gi];
         assign drive_data[gi] = periph.sel[gi] ? periph.data[gi] : output_latch_r[gi];
         assign od_mode[gi]    = open_drain_control_r[gi] | periph.od_force[gi];
         // open-drain drives only the low level
         assign pad_ctl.oe[gi]  = drive_en[gi] & (~od_mode[gi] | ~drive_data[gi]);
         assign pad_ctl.out[gi] = drive_data[gi] & ~od_mode[gi];
         assign pad_ctl.slew_limit[gi] = slew_limit_control_r[gi];
         assign pad_ctl.pullup_en[gi]  = weak_pullup_control_r[gi] & ~drive_en[gi];
         assign pad_ctl.ccd_rise[gi]   = const_current_rise_enable_r[gi] & const_current_global_enable_r;
         assign pad_ctl.ccd_fall[gi]   = const_current_fall_enable_r[gi] & const_current_global_enable_r;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   AST_DIR_HIZ: assert property ((pad_ctl.oe & pin_direction_r) == '0)
      else $error("driver enabled on an input pin");

   AST_DRIVE_LATCH: assert property (
      ((~pin_direction_r & ~INPUT_ONLY_MASK & ~periph.sel & ~open_drain_control_r & ~periph.od_force)
         & ((pad_ctl.out ^ output_latch_r) | ~pad_ctl.oe)) == '0)
      else $error("output pin not driven from latch");

   AST_PORT_READ: assert property (setup_ph && !pwrite && paddr == OFF_PORT_VALUE
      |=> prdata[PORT_W-1:0] == $past(port_read))
      else $error("port read does not return pin state");

   AST_RMW: assert property (access_ph && pwrite && paddr == OFF_PORT_VALUE && !pstrb[0]
      |=> (output_latch_r & ~INPUT_ONLY_MASK) == ($past(port_read) & ~INPUT_ONLY_MASK))
      else $error("port write did not store sampled pins");

   AST_LATCH_WR: assert property (access_ph && pwrite && pstrb[0]
      && (paddr == OFF_LATCH || paddr == OFF_PORT_VALUE)
      ##1 !(access_ph && pwrite) [*2]
      |-> (output_latch_r & ~INPUT_ONLY_MASK) == ($past(pwdata[PORT_W-1:0], 2) & ~INPUT_ONLY_MASK))
      else $error("latch lost the most recent write");

   AST_ANALOG_ZERO: assert property ((port_read & analog_select_r & ~mclr_mask) == '0)
      else $error("analog pin read nonzero");

   AST_ANALOG_NO_OUT: assert property ((pad_ctl.oe & ~pin_direction_r & ~INPUT_ONLY_MASK)
      == (~pin_direction_r & ~INPUT_ONLY_MASK & (~od_mode | ~drive_data)))
      else $error("analog select changed output drive");

   AST_OPEN_DRAIN: assert property ((pad_ctl.out & od_mode) == '0)
      else $error("open-drain pin sourcing current");

   AST_PULLUP_OFF: assert property ((pad_ctl.pullup_en & ~pin_direction_r) == '0)
      else $error("pull-up active on an output");

   AST_CCD_GATE: assert property (!const_current_global_enable_r
      |-> (pad_ctl.ccd_rise | pad_ctl.ccd_fall) == '0)
      else $error("constant current without global enable");

   AST_BIT3: assert property (!pad_ctl.oe[POS_INPUT_ONLY]
      && (master_clear_pin_enable -> port_read[POS_INPUT_ONLY]))
      else $error("input-only pin misbehaves");

   AST_ANSEL_RST: assert property (@(posedge mclk) disable iff (1'b0)
      !rst_n |=> analog_select_r == RST_ANALOG)
      else $error("analog select not reset to analog");

   ////////////////////////////////////////////////////////////////////////////
   // register write effects, one cycle after the access edge

   AST_DIR_WR: assert property (wr_en && lane0 && paddr == OFF_DIRECTION
      |=> pin_direction_r == ($past(pwdata[PORT_W-1:0]) | INPUT_ONLY_MASK))
      else $error("direction write not applied");

   AST_SLEW_WR: assert property (wr_en && lane0 && paddr == OFF_SLEW
      |=> pad_ctl.slew_limit == $past(pwdata[PORT_W-1:0]))
      else $error("slew write not applied");

   AST_PULLUP_WR: assert property (wr_en && lane0 && paddr == OFF_PULLUP
      |=> weak_pullup_control_r == $past(pwdata[PORT_W-1:0]))
      else $error("pull-up write not applied");

   AST_ANALOG_WR: assert property (wr_en && lane0 && paddr == OFF_ANALOG
      |=> analog_select_r == $past(pwdata[PORT_W-1:0]))
      else $error("analog select write not applied");

   AST_OD_WR: assert property (wr_en && lane0 && paddr == OFF_OPEN_DRAIN
      |=> open_drain_control_r == $past(pwdata[PORT_W-1:0]))
      else $error("open-drain write not applied");

   AST_CCD_WR: assert property (wr_en && lane0 && paddr == OFF_CCD_CTRL
      |=> const_current_global_enable_r == $past(pwdata[POS_CCD_EN]))
      else $error("constant current enable write not applied");

   AST_LATCH_BIT3: assert property (wr_port || wr_latch
      |=> output_latch_r[POS_INPUT_ONLY] == $past(output_latch_r[POS_INPUT_ONLY]))
      else $error("input-only latch bit written");

   ////////////////////////////////////////////////////////////////////////////
   // pad drive, input selection and read data

   AST_DIR_BIT3: assert property (pin_direction_r[POS_INPUT_ONLY])
      else $error("input-only pin set as output");

   AST_PULLUP_ON: assert property ((weak_pullup_control_r & pin_direction_r & ~pad_ctl.pullup_en) == '0)
      else $error("pull-up missing on an input pin");

   AST_OD_SINK: assert property ((drive_en & od_mode & ~drive_data & ~pad_ctl.oe) == '0)
      else $error("open-drain pin not sinking a low");

   AST_PERIPH_OUT: assert property (
      (drive_en & periph.sel & ~od_mode & (~pad_ctl.oe | (pad_ctl.out ^ periph.data))) == '0)
      else $error("selected peripheral not driving its pin");

   AST_CCD_ON: assert property (const_current_global_enable_r
      |-> pad_ctl.ccd_rise == const_current_rise_enable_r && pad_ctl.ccd_fall == const_current_fall_enable_r)
      else $error("constant current bit not passed through");

   AST_SCHMITT_SEL: assert property (
      ((port_read ^ schmitt_s2_r) & input_threshold_select_r & ~analog_select_r & ~mclr_mask) == '0)
      else $error("schmitt input not used for read");

   AST_TTL_SEL: assert property (
      ((port_read ^ ttl_s2_r) & ~input_threshold_select_r & ~analog_select_r & ~mclr_mask) == '0)
      else $error("ttl input not used for read");

   AST_UNMAPPED_RD: assert property (setup_ph && !pwrite && !addr_hit
      |=> prdata == '0)
      else $error("unmapped read returned data");

   AST_PRDATA_HI: assert property (prdata[31:PORT_W] == '0)
      else $error("read data upper bits set");

   ////////////////////////////////////////////////////////////////////////////
   // reset behaviour and coverage

   AST_POR_LOAD: assert property (@(posedge mclk) disable iff (1'b0) !rst_n && por_reset
      |=> pin_direction_r == POR_DIRECTION && output_latch_r == POR_LATCH
         && weak_pullup_control_r == POR_PULLUP && open_drain_control_r == POR_OPEN_DRAIN)
      else $error("power-on reset values not loaded");

   AST_WARM_KEEP: assert property (@(posedge mclk) disable iff (1'b0) !rst_n && !por_reset
      |=> pin_direction_r == $past(pin_direction_r) && output_latch_r == $past(output_latch_r)
         && weak_pullup_control_r == $past(weak_pullup_control_r))
      else $error("warm reset disturbed kept registers");

   COV_PORT_READ: cover property (setup_ph && !pwrite && paddr == OFF_PORT_VALUE);
   COV_PORT_WRITE: cover property (wr_port);
   COV_LATCH_WRITE: cover property (wr_latch ##1 pad_ctl.oe != '0);
   COV_UNMAPPED: cover property (pslverr);
   COV_OD_FORCE: cover property (periph.od_force != '0 && pad_ctl.oe != '0);

endmodule : epd_port

// file: epd_pad_model.sv
// pad model: resolves pin levels from the port drive and the outside circuit
module epd_pad_model
   import epd_pkg::*;
(
   input  wire epd_pad_ctl_s       pad_ctl,
   input  wire logic [PORT_W-1:0]  ext_level,
   input  wire logic [PORT_W-1:0]  ttl_flip,
   output logic      [PORT_W-1:0]  pad_schmitt_in,
   output logic      [PORT_W-1:0]  pad_ttl_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [PORT_W-1:0] lvl;
   // driven pins win, then the weak pull-up, then the outside circuit
   assign lvl = (pad_ctl.oe & pad_ctl.out) | (~pad_ctl.oe & (pad_ctl.pullup_en | ext_level));
   // ttl_flip models a level lying between the two thresholds
   assign pad_schmitt_in = lvl;
   assign pad_ttl_in     = lvl ^ ttl_flip;
endmodule : epd_pad_model

// file: eight_bit_io_port_d_tb.sv
// self-checking bench for the eight-bit port
module eight_bit_io_port_d_tb import epd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic         mclk = 1'b0, rst_n = 1'b0, por_reset = 1'b1, psel = 1'b0, penable = 1'b0;
   logic         pwrite = 1'b0, mce = 1'b0, pready, pslverr, e;
   logic [7:0]   paddr = '0, ext = '0, flip = '0, pin_digital_in, sch, ttl;
   logic [7:0]   dir, lat, an, thr, pu, de, outx, lvl, ex;
   logic [31:0]  pwdata = '0, prdata, q;
   logic [3:0]   pstrb = '0;
   logic [15:0]  rnd = 16'h000f;
   logic [63:0]  r;
   epd_periph_s  periph = '0;
   epd_pad_ctl_s pad_ctl;
   int           bad_count = 0, checks = 0;
   localparam logic [7:0] ra [10] = '{OFF_DIRECTION, OFF_LATCH, OFF_ANALOG, OFF_THRESHOLD, OFF_OPEN_DRAIN,
                                      OFF_SLEW, OFF_PULLUP, OFF_CCD_RISE, OFF_CCD_FALL, OFF_CCD_CTRL};
   localparam logic [7:0] rv [10] = '{POR_DIRECTION, POR_LATCH, RST_ANALOG, RST_THRESHOLD, POR_OPEN_DRAIN,
                                      RST_SLEW, POR_PULLUP, RST_CCD, RST_CCD, 8'h00};

   always #25 mclk = ~mclk;

   epd_port i_dut (.mclk(mclk), .rst_n(rst_n), .por_reset(por_reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pad_schmitt_in(sch), .pad_ttl_in(ttl), .master_clear_pin_enable(mce),
      .periph(periph), .pad_ctl(pad_ctl), .pin_digital_in(pin_digital_in));
   epd_pad_model i_pads (.pad_ctl(pad_ctl), .ext_level(ext), .ttl_flip(flip), .pad_schmitt_in(sch),
      .pad_ttl_in(ttl));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] nxt(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt

   function automatic logic [7:0] rd_exp(logic [7:0] lv, fl, th, a, logic mc);
      logic [7:0] v;
      v = ((th & lv) | (~th & (lv ^ fl))) & ~a;
      v[3] = v[3] | mc;
      return v;
   endfunction : rd_exp

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic chk(string n, logic [7:0] x, logic [7:0] got);
      checks++;
      if (got !== x) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, x, got);
      end
   endtask : chk

   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(logic [7:0] a, logic [7:0] d);
      apb(1'b1, a, {24'h000000, d}, 4'hf);
   endtask : wr

   task automatic rd(logic [7:0] a, logic [7:0] x, string n);
      apb(1'b0, a, 32'h00000000, 4'h0);
      chk(n, x, q[7:0]);
   endtask : rd

   // writes a configuration, lets the pad synchronisers settle, works out the pins
   task automatic setup(logic [7:0] d, l, a, t, p);
      epd_periph_s pk;
      dir = d;
      pu = p;
      wr(OFF_DIRECTION, d);
      wr(OFF_LATCH, l);
      wr(OFF_ANALOG, a);
      // peripheral drive parked while the threshold changes
      pk = periph;
      periph <= '0;
      wr(OFF_THRESHOLD, t);
      periph <= pk;
      wr(OFF_PULLUP, p);
      repeat (3) @(posedge mclk);
      de = d | INPUT_ONLY_MASK;
      outx = (periph.sel & periph.data) | (~periph.sel & l);
      lvl = (~de & outx) | (de & (p | ext));
      ex = rd_exp(lvl, flip, t, a, mce);
   endtask : setup

   task automatic check_pins();
      chk("oe", ~de, pad_ctl.oe);
      chk("out", outx & ~de, pad_ctl.out & ~de);
      chk("pullup", pu & de, pad_ctl.pullup_en);
      chk("digital_in", ex, pin_digital_in);
      rd(OFF_PORT_VALUE, ex, "port_read");
   endtask : check_pins

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++)
         rd(ra[i], rv[i], "reset_value");
      apb(1'b0, 8'h2c, 32'h00000000, 4'h0);
      chk("unmapped_err", 8'h01, {7'h00, e});
      chk("unmapped_data", 8'h00, q[7:0]);
      $display("test reset done");
      mce <= 1'b1;
      ext <= 8'hff;
      setup(8'h00, 8'hff, 8'hff, 8'hff, 8'h00);
      check_pins();
      mce <= 1'b0;
      flip <= 8'hff;
      setup(8'hff, 8'h00, 8'h00, 8'h00, 8'h00);
      check_pins();
      for (int i = 0; i < 40; i++) begin
         for (int k = 0; k < 4; k++) begin
            rnd = nxt(rnd);
            r[16*k +: 16] = rnd;
         end
         ext <= r[31:24];
         flip <= r[23:16];
         mce <= r[16];
         periph <= {r[7:0], r[15:8], 8'h00};
         setup(r[39:32], r[47:40], r[55:48], r[63:56], r[15:8] ^ r[55:48]);
         check_pins();
      end
      $display("test random done");
      periph <= '0;
      ext <= 8'hf7;
      flip <= 8'h00;
      mce <= 1'b0;
      setup(8'hf0, 8'h5a, 8'h00, 8'hff, 8'h00);
      apb(1'b1, OFF_PORT_VALUE, 32'h00000000, 4'h0);
      rd(OFF_LATCH, ex, "latch_rmw");
      wr(OFF_PORT_VALUE, 8'h3c);
      rd(OFF_LATCH, 8'h34, "latch_port_write");
      wr(OFF_LATCH, 8'h81);
      rd(OFF_LATCH, 8'h81, "latch_last");
      $display("test latch done");
      por_reset <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(OFF_DIRECTION, 8'hf8, "dir_kept");
      rd(OFF_LATCH, 8'h81, "latch_kept");
      rd(OFF_ANALOG, RST_ANALOG, "analog_reset");
      $display("test warm reset done");
      periph <= {8'h00, 8'h00, 8'hf0};
      wr(OFF_OPEN_DRAIN, 8'h0f);
      wr(OFF_SLEW, 8'h0f);
      wr(OFF_CCD_CTRL, 8'h80);
      wr(OFF_CCD_RISE, 8'h33);
      wr(OFF_CCD_FALL, 8'hcc);
      wr(OFF_DIRECTION, 8'h00);
      wr(OFF_LATCH, 8'hff);
      @(posedge mclk);
      chk("od_high", 8'h00, pad_ctl.oe & pad_ctl.out);
      chk("slew", 8'h0f, pad_ctl.slew_limit);
      chk("ccd_rise", 8'h33, pad_ctl.ccd_rise);
      chk("ccd_fall", 8'hcc, pad_ctl.ccd_fall);
      rd(OFF_CCD_CTRL, 8'h80, "ccd_ctrl");
      wr(OFF_LATCH, 8'h00);
      @(posedge mclk);
      chk("od_low", 8'hf7, pad_ctl.oe & ~pad_ctl.out);
      $display("test drive done");
      test_done();
   end

   initial begin
      repeat (6000) @(posedge mclk);
      bad_count++;
      test_done();
   end
endmodule : eight_bit_io_port_d_tb
